// File: rtl/bcd_alu_pkg.sv
// Package with opcodes, flag positions, corrections and cycle counts for the adjust/decrement ALU
package bcd_alu_pkg;
  // Opcodes: direct form first, indirect form second
  localparam logic [7:0] OPC_ADJ_DIRECT   = 8'h40;
  localparam logic [7:0] OPC_ADJ_INDIRECT = 8'h41;
  localparam logic [7:0] OPC_DEC_DIRECT   = 8'h00;
  localparam logic [7:0] OPC_DEC_INDIRECT = 8'h01;
  localparam logic [7:0] OPC_WORD_DECREMENT_OP_PAIR    = 8'h80;
  localparam logic [7:0] OPC_WORD_DECREMENT_OP_IND     = 8'h81;
  // Cycle counts per operation
  localparam logic [3:0] CYC_BYTE_OP = 4'h4;
  localparam logic [3:0] CYC_WORD_OP = 4'h8;
  // Flag register bit positions
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;
  // Decimal correction values
  localparam logic [7:0] CORR_NONE    = 8'h00;
  localparam logic [7:0] CORR_ADD_LO  = 8'h06;
  localparam logic [7:0] CORR_ADD_HI  = 8'h60;
  localparam logic [7:0] CORR_ADD_BTH = 8'h66;
  localparam logic [7:0] CORR_SUB_LO  = 8'hFA;
  localparam logic [7:0] CORR_SUB_HI  = 8'hA0;
  localparam logic [7:0] CORR_SUB_BTH = 8'h9A;
  // Nibble thresholds
  localparam logic [3:0] NIB_NINE  = 4'h9;
  localparam logic [3:0] NIB_EIGHT = 4'h8;
  // Reset value of the flag register
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  typedef enum logic [1:0] {OP_ADJ, OP_DEC, OP_WORD_DECREMENT_OP} op_e;
endpackage

// File: rtl/bcd_correction.sv
// Combinational decimal-adjust correction selector
`timescale 1ns/1ps
module bcd_correction
  import bcd_alu_pkg::*;
(
  input  wire logic [7:0] i_value,
  input  wire logic       i_carry,
  input  wire logic       i_half,
  input  wire logic       i_subtract,
  output logic      [7:0] o_corr,
  output logic            o_carry
);
  logic lo_fix;
  logic hi_fix;
  logic lo_big;

  // Choose correction; the decimal-mode flag tells add from subtract
  always_comb begin
    lo_big = i_value[3:0] > NIB_NINE;
    lo_fix = lo_big || i_half;
    hi_fix = i_carry || (i_value[7:4] > NIB_NINE) || ((i_value[7:4] > NIB_EIGHT) && lo_big);
    if (!i_subtract) begin
      o_corr  = lo_fix ? (hi_fix ? CORR_ADD_BTH : CORR_ADD_LO)
                       : (hi_fix ? CORR_ADD_HI  : CORR_NONE);
      o_carry = hi_fix;
    end else begin
      // Only the flags pick the subtract correction; digits are assumed valid
      o_corr  = i_half ? (i_carry ? CORR_SUB_BTH : CORR_SUB_LO)
                       : (i_carry ? CORR_SUB_HI  : CORR_NONE);
      o_carry = i_carry;
    end
  end
endmodule // bcd_correction

// File: rtl/pair_decrement.sv
// Parameterised decrement with zero, sign and signed-overflow flags
`timescale 1ns/1ps
module pair_decrement #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] i_value,
  output logic      [WIDTH-1:0] o_value,
  output logic                  o_zero,
  output logic                  o_sign,
  output logic                  o_ovf
);
  // Overflow only when the most negative value steps down to the most positive one
  always_comb begin
    o_value = i_value - {{(WIDTH-1){1'b0}}, 1'b1};
    o_zero  = (o_value == '0);
    o_sign  = o_value[WIDTH-1];
    o_ovf   = !i_value[WIDTH-1] ? 1'b0 : !o_value[WIDTH-1];
  end
endmodule // pair_decrement

// File: rtl/bcd_adjust_and_decrement_alu.sv
// Adjust/decrement ALU: decimal adjust, byte decrement and word decrement with flag update
`timescale 1ns/1ps
module bcd_adjust_and_decrement_alu
  import bcd_alu_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_sys_rst,
  input  wire logic       i_start,
  input  wire logic [7:0] i_opcode,
  input  wire logic [7:0] i_dst_addr,
  input  wire logic [7:0] i_operand_hi,
  input  wire logic [7:0] i_operand_lo,
  input  wire logic [7:0] i_flags,
  output logic            o_busy,
  output logic            o_done,
  output logic            o_write_lo,
  output logic            o_write_hi,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_result_hi,
  output logic      [7:0] o_result_lo,
  output logic      [7:0] o_flags,
  output logic            o_indirect,
  output logic            o_illegal
);
  typedef enum logic [1:0] {ST_IDLE, ST_RUN} state_e;

  state_e     state;
  op_e        op;
  logic [3:0] cycle_cnt;
  logic [7:0] in_hi;
  logic [7:0] in_lo;
  logic [7:0] in_flags;
  logic [7:0] adj_corr;
  logic       adj_carry;
  logic [7:0] adj_value;
  logic [7:0] dec8_value;
  logic       dec8_z;
  logic       dec8_s;
  logic       dec8_v;
  logic [15:0] dec16_value;
  logic       dec16_z;
  logic       dec16_s;
  logic       dec16_v;
  logic       opc_known;
  op_e        next_op;
  logic [3:0] next_len;
  logic       next_ind;
  logic [7:0] next_flags;

  // Decode the opcode pair into an operation, its length and addressing form
  always_comb begin
    opc_known = 1'b1;
    next_op   = OP_ADJ;
    next_len  = CYC_BYTE_OP;
    next_ind  = i_opcode[0];
    unique case (i_opcode)
      OPC_ADJ_DIRECT, OPC_ADJ_INDIRECT: next_op = OP_ADJ;
      OPC_DEC_DIRECT, OPC_DEC_INDIRECT: next_op = OP_DEC;
      OPC_WORD_DECREMENT_OP_PAIR, OPC_WORD_DECREMENT_OP_IND: begin
        next_op  = OP_WORD_DECREMENT_OP;
        next_len = CYC_WORD_OP;
      end
      default: opc_known = 1'b0;
    endcase
  end

  // Correction selection; inputs are the latched operand and flags
  bcd_correction u_corr (
    .i_value    (in_lo),
    .i_carry    (in_flags[FLAG_C]),
    .i_half     (in_flags[FLAG_H]),
    .i_subtract (in_flags[FLAG_D]),
    .o_corr     (adj_corr),
    .o_carry    (adj_carry)
  );

  // Adjusted byte; an invalid BCD input just gives whatever the sum yields
  assign adj_value = in_lo + adj_corr;

  pair_decrement #(.WIDTH(8)) u_dec8 (
    .i_value (in_lo),
    .o_value (dec8_value),
    .o_zero  (dec8_z),
    .o_sign  (dec8_s),
    .o_ovf   (dec8_v)
  );

  pair_decrement #(.WIDTH(16)) u_dec16 (
    .i_value ({in_hi, in_lo}),
    .o_value (dec16_value),
    .o_zero  (dec16_z),
    .o_sign  (dec16_s),
    .o_ovf   (dec16_v)
  );

  // Flag result per operation; untouched flags pass through
  always_comb begin
    next_flags = in_flags;
    unique case (op)
      OP_ADJ: begin
        next_flags[FLAG_C] = adj_carry;
        next_flags[FLAG_Z] = (adj_value == 8'h00);
        next_flags[FLAG_S] = adj_value[7];
        // Overflow left as it was: undefined by the architecture
      end
      OP_DEC: begin
        next_flags[FLAG_Z] = dec8_z;
        next_flags[FLAG_S] = dec8_s;
        next_flags[FLAG_V] = dec8_v;
      end
      OP_WORD_DECREMENT_OP: begin
        // Zero is computed honestly from all 16 bits, though software should not lean on it
        next_flags[FLAG_Z] = dec16_z;
        next_flags[FLAG_S] = dec16_s;
        next_flags[FLAG_V] = dec16_v;
      end
      default: next_flags = in_flags;
    endcase
  end

  // Sequencer: latch operands on start, count the documented cycles, then write back
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state     <= ST_IDLE;
      op        <= OP_ADJ;
      cycle_cnt <= 4'h0;
      in_hi     <= 8'h00;
      in_lo     <= 8'h00;
      in_flags  <= FLAGS_RESET;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (i_start && opc_known) begin
            state     <= ST_RUN;
            op        <= next_op;
            cycle_cnt <= next_len - 4'h2;
            in_hi     <= i_operand_hi;
            in_lo     <= i_operand_lo;
            in_flags  <= i_flags;
          end
        end
        ST_RUN: begin
          if (cycle_cnt == 4'h0) begin
            state <= ST_IDLE;
          end else begin
            cycle_cnt <= cycle_cnt - 4'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Address and form, captured at start so the write goes back to the same place
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_addr     <= 8'h00;
      o_indirect <= 1'b0;
    end else if (state == ST_IDLE && i_start && opc_known) begin
      // Word form forces the pair base even; an odd name is a software fault
      o_addr     <= (next_op == OP_WORD_DECREMENT_OP) ? {i_dst_addr[7:1], 1'b0} : i_dst_addr;
      o_indirect <= next_ind;
    end
  end

  // Busy is high from the cycle after the start edge up to, but not in, the done cycle
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= (state == ST_IDLE) ? (i_start && opc_known) : (cycle_cnt != 4'h0);
    end
  end

  // Unknown opcodes are flagged for one cycle and otherwise ignored
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_illegal <= 1'b0;
    end else begin
      o_illegal <= (state == ST_IDLE) && i_start && !opc_known;
    end
  end

  // Result, write strobes and flags presented together with done
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_done      <= 1'b0;
      o_write_lo  <= 1'b0;
      o_write_hi  <= 1'b0;
      o_result_hi <= 8'h00;
      o_result_lo <= 8'h00;
      o_flags     <= FLAGS_RESET;
    end else begin
      o_done     <= 1'b0;
      o_write_lo <= 1'b0;
      o_write_hi <= 1'b0;
      if (state == ST_RUN && cycle_cnt == 4'h0) begin
        o_done  <= 1'b1;
        o_flags <= next_flags;
        unique case (op)
          OP_ADJ: begin
            o_result_lo <= adj_value;
            o_result_hi <= in_hi;
            o_write_lo  <= 1'b1;
          end
          OP_DEC: begin
            o_result_lo <= dec8_value;
            o_result_hi <= in_hi;
            o_write_lo  <= 1'b1;
          end
          OP_WORD_DECREMENT_OP: begin
            // High byte sits at the even address, low byte at the next
            o_result_hi <= dec16_value[15:8];
            o_result_lo <= dec16_value[7:0];
            o_write_hi  <= 1'b1;
            o_write_lo  <= 1'b1;
          end
          default: o_write_lo <= 1'b0;
        endcase
      end
    end
  end

  // Checks
  // Done is sampled high four edges after the start edge; the start cycle is the first of four
  property p_byte_len;
    @(posedge i_clock) disable iff (i_sys_rst)
      (state == ST_IDLE && i_start && opc_known && next_op != OP_WORD_DECREMENT_OP)
      |-> ##1 !o_done [*3] ##1 o_done;
  endproperty
  a_byte_len: assert property (p_byte_len)
    else $error("byte op did not finish in four cycles");
  // Repetition starts one edge late so a back-to-back done of the previous op is not blamed
  property p_word_len;
    @(posedge i_clock) disable iff (i_sys_rst)
      (state == ST_IDLE && i_start && opc_known && next_op == OP_WORD_DECREMENT_OP)
      |-> ##1 !o_done [*7] ##1 o_done;
  endproperty
  a_word_len: assert property (p_word_len)
    else $error("word op did not finish in eight cycles");
  property p_busy;
    @(posedge i_clock) disable iff (i_sys_rst)
      (state == ST_IDLE && i_start && opc_known) |-> ##1 o_busy;
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy not raised after a taken start");
  property p_illegal;
    @(posedge i_clock) disable iff (i_sys_rst)
      (state == ST_IDLE && i_start && !opc_known) |-> ##1 (o_illegal && !o_busy);
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("unknown opcode not refused");
  property p_flags_keep;
    @(posedge i_clock) disable iff (i_sys_rst)
      o_done |-> (o_flags[FLAG_D] == in_flags[FLAG_D] && o_flags[FLAG_H] == in_flags[FLAG_H]);
  endproperty
  a_flags_keep: assert property (p_flags_keep)
    else $error("D or H flag changed");
  property p_dec_carry;
    @(posedge i_clock) disable iff (i_sys_rst)
      (o_done && op != OP_ADJ) |-> o_flags[FLAG_C] == in_flags[FLAG_C];
  endproperty
  a_dec_carry: assert property (p_dec_carry)
    else $error("decrement changed carry");
  property p_dec_val;
    @(posedge i_clock) disable iff (i_sys_rst)
      (o_done && op == OP_DEC) |-> (o_result_lo == 8'(in_lo - 8'h01) && !o_write_hi);
  endproperty
  a_dec_val: assert property (p_dec_val)
    else $error("byte decrement wrong");
  property p_word_decrement_op_val;
    @(posedge i_clock) disable iff (i_sys_rst)
      (o_done && op == OP_WORD_DECREMENT_OP)
      |-> ({o_result_hi, o_result_lo} == 16'({in_hi, in_lo} - 16'h0001));
  endproperty
  a_word_decrement_op_val: assert property (p_word_decrement_op_val)
    else $error("word decrement wrong");
  property p_word_decrement_op_zero;
    @(posedge i_clock) disable iff (i_sys_rst)
      (o_done && op == OP_WORD_DECREMENT_OP) |-> o_flags[FLAG_Z] == ({o_result_hi, o_result_lo} == 16'h0000);
  endproperty
  a_word_decrement_op_zero: assert property (p_word_decrement_op_zero)
    else $error("word zero flag wrong");
  property p_adj_zero;
    @(posedge i_clock) disable iff (i_sys_rst)
      (o_done && op == OP_ADJ) |-> (o_flags[FLAG_Z] == (o_result_lo == 8'h00)
                                    && o_flags[FLAG_S] == o_result_lo[7]);
  endproperty
  a_adj_zero: assert property (p_adj_zero)
    else $error("adjust zero or sign wrong");
  property p_adj_add;
    @(posedge i_clock) disable iff (i_sys_rst)
      (o_done && op == OP_ADJ && !in_flags[FLAG_D] && in_flags[FLAG_C]) |-> o_flags[FLAG_C];
  endproperty
  a_adj_add: assert property (p_adj_add)
    else $error("add adjust lost carry");
  property p_adj_sub;
    @(posedge i_clock) disable iff (i_sys_rst)
      (o_done && op == OP_ADJ && in_flags[FLAG_D] && !in_flags[FLAG_C] && !in_flags[FLAG_H])
      |-> o_result_lo == in_lo;
  endproperty
  a_adj_sub: assert property (p_adj_sub)
    else $error("subtract adjust without flags changed value");
  property p_word_even;
    @(posedge i_clock) disable iff (i_sys_rst)
      (o_done && op == OP_WORD_DECREMENT_OP) |-> !o_addr[0];
  endproperty
  a_word_even: assert property (p_word_even)
    else $error("word pair address odd");
  c_adj: cover property (@(posedge i_clock) o_done && op == OP_ADJ);
  c_dec: cover property (@(posedge i_clock) o_done && op == OP_DEC && o_flags[FLAG_V]);
  c_word_decrement_op: cover property (@(posedge i_clock) o_done && op == OP_WORD_DECREMENT_OP && o_flags[FLAG_Z]);
endmodule // bcd_adjust_and_decrement_alu

// File: testbench/reg_file_model.sv
// Register file model standing behind the adjust/decrement ALU
`timescale 1ns/1ps
module reg_file_model (
  input  wire logic       i_clock,
  input  wire logic       i_write_lo,
  input  wire logic       i_write_hi,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_data_hi,
  input  wire logic [7:0] i_data_lo,
  input  wire logic [7:0] i_peek_addr,
  output logic      [7:0] o_peek_data,
  output logic            o_pair_zero
);
  logic [7:0] mem [256];
  // Word writes put the high byte at the even address and the low byte after it
  always_ff @(posedge i_clock) begin
    if (i_write_hi) begin
      mem[i_addr]         <= i_data_hi;
      mem[i_addr + 8'h01] <= i_data_lo;
    end else if (i_write_lo) begin
      mem[i_addr] <= i_data_lo;
    end
  end
  // Software tests a word for zero by ORing both bytes, not by the zero flag
  assign o_peek_data = mem[i_peek_addr];
  assign o_pair_zero = ~|(mem[i_peek_addr] | mem[i_peek_addr + 8'h01]);
endmodule // reg_file_model

// File: testbench/bcd_adjust_and_decrement_alu_tb_top.sv
// Self-checking bench for the adjust/decrement ALU
`timescale 1ns/1ps
module bcd_adjust_and_decrement_alu_tb_top;
  import bcd_alu_pkg::*;
  logic       i_clock      = 1'b0;
  logic       i_sys_rst    = 1'b1;
  logic       i_start      = 1'b0;
  logic [7:0] i_opcode     = 8'h00;
  logic [7:0] i_dst_addr   = 8'h00;
  logic [7:0] i_operand_hi = 8'h00;
  logic [7:0] i_operand_lo = 8'h00;
  logic [7:0] i_flags      = 8'h00;
  logic [7:0] peek_addr    = 8'h00;
  logic       o_busy, o_done, o_write_lo, o_write_hi, o_indirect, o_illegal, pair_zero;
  logic [7:0] o_addr, o_result_hi, o_result_lo, o_flags, peek_data;
  int         n_mismatch   = 0;
  int         check_count  = 0;
  logic [63:0] v;
  // Fields: opcode, addr, hi, lo, flags in, result hi, result lo, flags out
  // Word addresses are all even, as software must give them
  localparam logic [63:0] VEC [17] = '{
    64'h40_10_00_3C_10_00_42_10, 64'h41_11_00_9A_00_00_00_C0,
    64'h40_12_00_02_04_00_08_04, 64'h41_13_00_12_80_00_72_80,
    64'h40_14_00_2E_0C_00_28_0C, 64'h41_15_00_F1_88_00_91_A8,
    64'h40_16_00_EE_8C_00_88_AC, 64'h41_17_00_31_08_00_31_08,
    64'h00_20_00_10_8C_00_0F_8C, 64'h01_21_00_01_00_00_00_40,
    64'h00_22_00_80_00_00_7F_10, 64'h01_23_00_00_00_00_FF_20,
    64'h80_30_12_34_00_12_33_00, 64'h81_32_01_00_00_00_FF_00,
    64'h80_34_00_01_8C_00_00_CC, 64'h81_36_80_00_00_7F_FF_10,
    64'h80_38_00_00_00_FF_FF_20};

  always #2.5 i_clock = ~i_clock;

  bcd_adjust_and_decrement_alu dut_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_start(i_start), .i_opcode(i_opcode), .i_dst_addr(i_dst_addr),
    .i_operand_hi(i_operand_hi), .i_operand_lo(i_operand_lo), .i_flags(i_flags),
    .o_busy(o_busy), .o_done(o_done), .o_write_lo(o_write_lo), .o_write_hi(o_write_hi),
    .o_addr(o_addr), .o_result_hi(o_result_hi), .o_result_lo(o_result_lo),
    .o_flags(o_flags), .o_indirect(o_indirect), .o_illegal(o_illegal));

  reg_file_model rf_u (.i_clock(i_clock), .i_write_lo(o_write_lo), .i_write_hi(o_write_hi),
    .i_addr(o_addr), .i_data_hi(o_result_hi), .i_data_lo(o_result_lo),
    .i_peek_addr(peek_addr), .o_peek_data(peek_data), .o_pair_zero(pair_zero));

  task automatic finish_test();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One operation; a second start is pushed in while busy and must be dropped
  task automatic run(input logic [63:0] vec);
    int n;
    n = 0;
    @(posedge i_clock);
    i_start      <= 1'b1;
    i_opcode     <= vec[63:56];
    i_dst_addr   <= vec[55:48];
    i_operand_hi <= vec[47:40];
    i_operand_lo <= vec[39:32];
    i_flags      <= vec[31:24];
    @(posedge i_clock);
    i_start <= 1'b0;
    do begin
      @(posedge i_clock);
      n++;
      i_start      <= (n == 2);
      i_operand_lo <= ~vec[39:32];
      #1;
      if (n == 1) check("busy", 16'(o_busy), 16'h0001);
    end while (o_done !== 1'b1 && n < 20);
    if (o_done !== 1'b1) begin
      n_mismatch++;
      finish_test();
    end
    // The request cycle itself is the first of the operation's cycles
    check("latency", 16'(n + 1), 16'(vec[63] ? CYC_WORD_OP : CYC_BYTE_OP));
    check("write", 16'({o_write_hi, o_write_lo}), 16'({vec[63], 1'b1}));
    check("indirect", 16'(o_indirect), 16'(vec[56]));
    check("addr", 16'(o_addr), 16'(vec[55:48]));
    @(posedge i_clock);
    peek_addr = vec[55:48];
    #1;
    // Done stands one cycle only, and the start pushed in while busy must leave no trace
    check("done_end", 16'({o_done, o_busy}), 16'h0000);
  endtask

  initial begin
    repeat (16) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    @(posedge i_clock);
    #1;
    check("reset", 16'({o_busy, o_done, o_flags}), 16'h0000);
    for (int i = 0; i < 17; i++) begin
      v = VEC[i];
      run(v);
      if (i < 8) begin
        check("adj_result", 16'(o_result_lo), 16'(v[15:8]));
        check("adj_carry", 16'(o_flags[FLAG_C]), 16'(v[FLAG_C]));
        check("adj_flags", 16'(o_flags), 16'(v[7:0]));
        check("adj_wb", 16'(peek_data), 16'(v[15:8]));
      end else if (i < 12) begin
        check("dec_wb", 16'(peek_data), 16'(v[15:8]));
        check("dec_flags", 16'(o_flags), 16'(v[7:0]));
      end else begin
        check("word_result", {o_result_hi, o_result_lo}, v[23:8]);
        check("word_flags", 16'(o_flags), 16'(v[7:0]));
        check("word_zero", 16'(pair_zero), 16'(v[23:8] == 16'h0000));
        check("word_wb_hi", 16'(peek_data), 16'(v[23:16]));
        peek_addr = v[55:48] + 8'h01;
        #1;
        check("word_wb_lo", 16'(peek_data), 16'(v[15:8]));
      end
    end
    // Unknown opcode: a one-cycle refusal pulse and no completion
    @(posedge i_clock);
    i_start  <= 1'b1;
    i_opcode <= 8'h55;
    @(posedge i_clock);
    i_start <= 1'b0;
    #1;
    check("illegal", 16'({o_illegal, o_done}), 16'h0002);
    @(posedge i_clock);
    #1;
    check("illegal_end", 16'({o_illegal, o_done, o_busy}), 16'h0000);
    finish_test();
  end
endmodule // bcd_adjust_and_decrement_alu_tb_top
